// ===== rtl/afs_timing.sv
// light start delay and sub-sampling timing core with register file
module afs_timing
    import afs_pkg::*;
(
    input  wire logic       CORE_CLK,       // core clock, 100 MHz
    input  wire logic       RST,            // async reset, active high
    input  wire logic [7:0] REG_ADDR,       // register offset
    input  wire logic [7:0] REG_WDATA,      // write data
    input  wire logic       REG_WR,         // write strobe
    input  wire logic       REG_RD,         // read strobe
    output logic      [7:0] REG_RDATA,      // read data, valid cycle after strobe
    input  wire logic       FRAME_SYNC,     // display frame-sync pin
    input  wire logic       MEAS_EN,        // integration enabled; low is idle
    input  wire logic       INTEG_DONE,     // end of integration-time period
    input  wire logic [7:0] EVENT_IN,       // raw event sources, bit per enable
    output logic      [7:0] EVENT_GATED,    // events passed by the enable register
    output logic            INTEG_START,    // pulse: light integration begins
    output logic            SAMPLE_STROBE,  // pulse: take a light sample
    output logic            SAMPLE_PHASE,   // period of the strobe: 0 one, 1 two
    output logic            DELAYING        // start delay running
);
    typedef struct packed {
        logic       sync1;
        logic       sync2;
        logic       sync3;
        logic [7:0] irq_en2;
        logic [7:0] delay_low;
        logic [7:0] delay_high;
        logic [7:0] sub_one_low;
        logic [7:0] sub_one_high;
        logic [7:0] sub_two_low;
        logic [7:0] sub_two_high;
        afs_state_t st;
        logic [15:0] cnt;
        logic       phase;
        logic [7:0] rdata;
        logic [7:0] gated;
        logic       integ_start;
        logic       strobe;
        logic       strobe_phase;
        logic       delaying;
    } afs_core_state_t;

    afs_core_state_t cur;
    afs_core_state_t next_cur;
    afs_tick_if      tk ();

    logic        frame_edge;
    logic [15:0] light_start_delay;
    logic [15:0] delay_target;
    logic [13:0] sub_sample_period_one;
    logic [13:0] sub_sample_period_two;
    logic [13:0] period_now;

    afs_tick_gen u_tick (
        .CORE_CLK (CORE_CLK),
        .RST      (RST),
        .tk       (tk)
    );

    // ==========================================================
    // derived values
    assign frame_edge = cur.sync2 & ~cur.sync3;
    assign light_start_delay = {cur.delay_high, cur.delay_low};
    // short delays would end inside the init period, so init time rules
    assign delay_target = (light_start_delay > INIT_TICKS) ? light_start_delay
                                                           : INIT_TICKS;
    assign sub_sample_period_one = afs_join14(cur.sub_one_high, cur.sub_one_low);
    assign sub_sample_period_two = afs_join14(cur.sub_two_high, cur.sub_two_low);
    assign period_now = cur.phase ? sub_sample_period_two : sub_sample_period_one;
    // aligning the tick phase to a frame-sync edge seen outside AFS_INTEG keeps delay jitter under one clock
    assign tk.restart = frame_edge & MEAS_EN & (cur.st != AFS_INTEG);

    // ==========================================================
    // next state
    always_comb
    begin
        next_cur = cur;
        next_cur.sync1 = FRAME_SYNC;
        next_cur.sync2 = cur.sync1;
        next_cur.sync3 = cur.sync2;
        next_cur.integ_start = 1'b0;
        next_cur.strobe = 1'b0;
        next_cur.gated = EVENT_IN & cur.irq_en2 & IRQ_EN_MASK;

        // register file
        if (REG_WR)
        begin
            case (REG_ADDR)
                OFS_IRQ_EN2:      next_cur.irq_en2 = REG_WDATA;
                OFS_DELAY_LOW:    next_cur.delay_low = REG_WDATA;
                OFS_DELAY_HIGH:   next_cur.delay_high = REG_WDATA;
                OFS_SUB_ONE_LOW:  next_cur.sub_one_low = REG_WDATA;
                OFS_SUB_ONE_HIGH: next_cur.sub_one_high = REG_WDATA;
                OFS_SUB_TWO_LOW:  next_cur.sub_two_low = REG_WDATA;
                OFS_SUB_TWO_HIGH: next_cur.sub_two_high = REG_WDATA;
                default:          next_cur.irq_en2 = cur.irq_en2;
            endcase
        end
        if (REG_RD)
        begin
            case (REG_ADDR)
                OFS_IRQ_EN2:      next_cur.rdata = cur.irq_en2;
                OFS_DELAY_LOW:    next_cur.rdata = cur.delay_low;
                OFS_DELAY_HIGH:   next_cur.rdata = cur.delay_high;
                OFS_SUB_ONE_LOW:  next_cur.rdata = cur.sub_one_low;
                OFS_SUB_ONE_HIGH: next_cur.rdata = cur.sub_one_high;
                OFS_SUB_TWO_LOW:  next_cur.rdata = cur.sub_two_low;
                OFS_SUB_TWO_HIGH: next_cur.rdata = cur.sub_two_high;
                default:          next_cur.rdata = UNMAPPED_READ;
            endcase
        end

        // timing sequence
        case (cur.st)
            AFS_IDLE:
            begin
                next_cur.cnt = COUNT_RESET;
                next_cur.phase = 1'b0;
                if (MEAS_EN && frame_edge)
                    next_cur.st = AFS_DELAY;
            end
            AFS_DELAY:
            begin
                if (frame_edge)
                begin
                    next_cur.cnt = COUNT_RESET;
                end
                else if (tk.tick)
                begin
                    if (16'(cur.cnt + 16'h0001) >= delay_target)
                    begin
                        next_cur.cnt = COUNT_RESET;
                        next_cur.phase = 1'b0;
                        next_cur.integ_start = 1'b1;
                        next_cur.st = AFS_INTEG;
                    end
                    else
                    begin
                        next_cur.cnt = 16'(cur.cnt + 16'h0001);
                    end
                end
            end
            AFS_INTEG:
            begin
                if (sub_sample_period_one == 14'h0000)
                begin
                    next_cur.cnt = COUNT_RESET;
                    if (INTEG_DONE)
                    begin
                        next_cur.strobe = 1'b1;
                        next_cur.strobe_phase = 1'b0;
                    end
                end
                else if (tk.tick)
                begin
                    if (16'(cur.cnt + 16'h0001) >= {2'b00, period_now})
                    begin
                        next_cur.cnt = COUNT_RESET;
                        next_cur.strobe = 1'b1;
                        next_cur.strobe_phase = cur.phase;
                        next_cur.phase = ~cur.phase;
                    end
                    else
                    begin
                        next_cur.cnt = 16'(cur.cnt + 16'h0001);
                    end
                end
                if (frame_edge)
                begin
                    next_cur.cnt = COUNT_RESET;
                    next_cur.phase = 1'b0;
                    next_cur.st = AFS_DELAY;
                end
            end
            default:
            begin
                next_cur.st = AFS_IDLE;
            end
        endcase

        if (!MEAS_EN)
        begin
            next_cur.st = AFS_IDLE;
            next_cur.cnt = COUNT_RESET;
            next_cur.integ_start = 1'b0;
            next_cur.strobe = 1'b0;
        end
        // registered copy of the state decode so the pin is glitch free
        next_cur.delaying = (next_cur.st == AFS_DELAY);
    end

    // ==========================================================
    // state register
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            cur <= '0;
            cur.st <= AFS_IDLE;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // ==========================================================
    // outputs, all straight from flops
    assign REG_RDATA     = cur.rdata;
    assign EVENT_GATED   = cur.gated;
    assign INTEG_START   = cur.integ_start;
    assign SAMPLE_STROBE = cur.strobe;
    assign SAMPLE_PHASE  = cur.strobe_phase;
    assign DELAYING      = cur.delaying;
endmodule

// ===== rtl/afs_pkg.sv
// constants, types and helpers shared by the frame-sync sample timing block
package afs_pkg;
    // ==========================================================
    // register offsets, reset value and unmapped read value
    localparam logic [7:0] OFS_IRQ_EN2      = 8'hDE;
    localparam logic [7:0] OFS_DELAY_LOW    = 8'hE0;
    localparam logic [7:0] OFS_DELAY_HIGH   = 8'hE1;
    localparam logic [7:0] OFS_SUB_ONE_LOW  = 8'hE2;
    localparam logic [7:0] OFS_SUB_ONE_HIGH = 8'hE3;
    localparam logic [7:0] OFS_SUB_TWO_LOW  = 8'hE4;
    localparam logic [7:0] OFS_SUB_TWO_HIGH = 8'hE5;
    localparam logic [7:0] REG_RESET        = 8'h00;
    localparam logic [7:0] UNMAPPED_READ    = 8'h00;

    // ==========================================================
    // interrupt enable field positions
    localparam int BIT_PWM_PERIOD_CHANGE = 7;
    localparam int BIT_EYE_SAFETY        = 4;
    localparam int BIT_INTEGRATION_DONE  = 3;
    localparam int BIT_FIFO_THRESHOLD    = 2;
    localparam int BIT_PROX_WAIT_DONE    = 1;
    localparam int BIT_LIGHT_WAIT_DONE   = 0;
    localparam logic [7:0] IRQ_EN_MASK   = 8'h9F;

    // ==========================================================
    // timing
    localparam int unsigned CLK_PERIOD_PS = 10000;
    localparam int unsigned TICK_PERIOD_PS = 1357000;
    localparam int ACC_W = 21;
    localparam logic [ACC_W-1:0] ACC_STEP  = ACC_W'(CLK_PERIOD_PS);
    localparam logic [ACC_W-1:0] ACC_LIMIT = ACC_W'(TICK_PERIOD_PS);
    localparam logic [15:0] INIT_TICKS     = 16'h0018;
    localparam logic [15:0] COUNT_RESET    = 16'h0000;

    // ==========================================================
    // types
    typedef enum logic [1:0] {AFS_IDLE, AFS_DELAY, AFS_INTEG} afs_state_t;

    function automatic logic [13:0] afs_join14(input logic [7:0] hi, input logic [7:0] lo);
        afs_join14 = {hi[5:0], lo};
    endfunction
endpackage

// ===== rtl/afs_tick_if.sv
// tick carrier between the tick generator and the timing core
interface afs_tick_if;
    logic tick;
    logic restart;
    modport gen (output tick, input restart);
    modport use_side (input tick, output restart);
endinterface

// ===== rtl/afs_tick_gen.sv
// fractional divider giving one-cycle 1.357 us tick enables
module afs_tick_gen
    import afs_pkg::*;
(
    input  wire logic CORE_CLK,  // core clock
    input  wire logic RST,       // async reset, active high
    afs_tick_if.gen   tk         // tick out, phase restart in
);
    typedef struct packed {
        logic [ACC_W-1:0] acc;
        logic             tick;
    } afs_tick_state_t;

    afs_tick_state_t cur;
    afs_tick_state_t next_cur;

    // ==========================================================
    // accumulator: period is not a whole number of clocks, so the
    // error is carried forward and the average rate stays exact
    always_comb
    begin
        next_cur = cur;
        next_cur.tick = 1'b0;
        if (tk.restart)
        begin
            next_cur.acc = '0;
        end
        else if (cur.acc + ACC_STEP >= ACC_LIMIT)
        begin
            next_cur.acc = ACC_W'(cur.acc + ACC_STEP - ACC_LIMIT);
            next_cur.tick = 1'b1;
        end
        else
        begin
            next_cur.acc = ACC_W'(cur.acc + ACC_STEP);
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
            cur <= '0;
        else
            cur <= next_cur;
    end

    assign tk.tick = cur.tick;
endmodule

// ===== tb/afs_display_model.sv
// display side: frame-sync pulses and integration-period ends
module afs_display_model
(
    input  wire logic CORE_CLK,   // core clock
    output logic      FRAME_SYNC, // frame-sync pin
    output logic      INTEG_DONE  // period end
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        FRAME_SYNC = 1'b0;
        INTEG_DONE = 1'b0;
    end
    // held four clocks so the input synchroniser cannot miss it
    task automatic pulse_sync();
        FRAME_SYNC = 1'b1;
        repeat (4) @(negedge CORE_CLK);
        FRAME_SYNC = 1'b0;
    endtask
    task automatic pulse_done();
        INTEG_DONE = 1'b1;
        @(negedge CORE_CLK);
        INTEG_DONE = 1'b0;
    endtask
endmodule

// ===== tb/afs_timing_sva.sv
// port assertions for the frame-sync sample timing block
module afs_sva
    import afs_pkg::*;
(
    input wire logic       CORE_CLK,      // clock
    input wire logic       RST,           // reset
    input wire logic [7:0] REG_ADDR,      // offset
    input wire logic [7:0] REG_WDATA,     // wdata
    input wire logic       REG_WR,        // write
    input wire logic       REG_RD,        // read
    input wire logic [7:0] REG_RDATA,     // rdata
    input wire logic       MEAS_EN,       // enable
    input wire logic [7:0] EVENT_IN,      // events
    input wire logic [7:0] EVENT_GATED,   // gated
    input wire logic       INTEG_START,   // start
    input wire logic       SAMPLE_STROBE, // sample
    input wire logic       DELAYING       // delay
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // ==========================================
    // length of the current delay run
    logic [15:0] dcnt;
    always_ff @(posedge CORE_CLK or posedge RST)
        if (RST)
            dcnt <= 16'h0000;
        else
            dcnt <= DELAYING ? dcnt + 16'h0001 : 16'h0000;
    // ==========================================
    // assertions
    gate_mask_a: assert property (EVENT_GATED == (EVENT_GATED & $past(EVENT_IN) & IRQ_EN_MASK))
        else $error("gated event without source");
    start_pulse_a: assert property (INTEG_START |=> !INTEG_START)
        else $error("start longer than one cycle");
    start_cause_a: assert property (INTEG_START |-> $past(DELAYING) && !DELAYING)
        else $error("start without delay");
    delay_min_a: assert property (INTEG_START |-> dcnt >= 16'h0C00)
        else $error("delay shorter than init time");
    delay_end_a: assert property ($fell(DELAYING) && $past(MEAS_EN, 2) && $past(MEAS_EN) |-> INTEG_START)
        else $error("delay ended without start");
    idle_stop_a: assert property (!MEAS_EN ##1 !MEAS_EN |-> !DELAYING && !INTEG_START)
        else $error("activity while idle");
    strobe_pulse_a: assert property (SAMPLE_STROBE |=> !SAMPLE_STROBE)
        else $error("strobe longer than one cycle");
    rd_hold_a: assert property (!$past(REG_RD) |-> $stable(REG_RDATA))
        else $error("read data changed without read");
    rd_back_a: assert property (REG_WR && REG_ADDR == OFS_IRQ_EN2 ##1 REG_RD && REG_ADDR == OFS_IRQ_EN2
        |=> REG_RDATA == $past(REG_WDATA, 2))
        else $error("read after write stale");
    cover property (INTEG_START);
    cover property (SAMPLE_STROBE);
    cover property ($fell(DELAYING) && !INTEG_START);
endmodule
bind afs_timing afs_sva u_sva (.CORE_CLK, .RST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
    .REG_RDATA, .MEAS_EN, .EVENT_IN, .EVENT_GATED, .INTEG_START, .SAMPLE_STROBE, .DELAYING);

// ===== tb/testbench.sv
// self-checking bench for the frame-sync sample timing block
module testbench
    import afs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       CORE_CLK, RST, REG_WR, REG_RD, MEAS_EN, FRAME_SYNC, INTEG_DONE;
    logic       INTEG_START, SAMPLE_STROBE, SAMPLE_PHASE, DELAYING, ph;
    logic [7:0] REG_ADDR, REG_WDATA, EVENT_IN, REG_RDATA, EVENT_GATED;
    int         errors = 0, n_checks = 0, cyc = 0, n;
    afs_timing dut (.CORE_CLK, .RST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
        .FRAME_SYNC, .MEAS_EN, .INTEG_DONE, .EVENT_IN, .EVENT_GATED, .INTEG_START,
        .SAMPLE_STROBE, .SAMPLE_PHASE, .DELAYING);
    afs_display_model disp (.CORE_CLK, .FRAME_SYNC, .INTEG_DONE);
    initial
    begin
        CORE_CLK = 1'b0;
        forever #5 CORE_CLK = ~CORE_CLK;
    end
    // about 68k cycles of tests; the margin covers tick rounding
    always @(posedge CORE_CLK)
        if (++cyc == 80000)
            wrap_up(1);
    task automatic wrap_up(input int hang);
        if (hang)
            $display("CHECK FAILED %0t timeout", $time);
        errors += hang;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %0t %s %h/%h", $time, m, got, exp);
        end
    endtask
    task automatic chkn(input int got, input int exp, input int tol, input string m);
        n_checks++;
        if (got < exp - tol || got > exp + tol)
        begin
            errors++;
            $display("CHECK FAILED %0t %s %0d/%0d", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        {REG_ADDR, REG_WDATA, REG_WR} = {a, d, 1'b1};
        @(negedge CORE_CLK) REG_WR = 1'b0;
        @(negedge CORE_CLK);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        {REG_ADDR, REG_RD} = {a, 1'b1};
        @(negedge CORE_CLK) REG_RD = 1'b0;
        chk8(REG_RDATA, exp, "read");
        @(negedge CORE_CLK);
    endtask
    task automatic wait_start();
        for (n = 0; INTEG_START !== 1'b1 && n < 40000; n++)
            @(negedge CORE_CLK);
    endtask
    task automatic wait_strobe();
        for (n = 0; SAMPLE_STROBE !== 1'b1 && n < 5000; n++)
            @(negedge CORE_CLK);
        ph = SAMPLE_PHASE;
        @(negedge CORE_CLK);
    endtask
    task automatic run_delay(input logic [7:0] hi, lo, input int ticks);
        MEAS_EN = 1'b0;
        repeat (2) @(negedge CORE_CLK) MEAS_EN = 1'b1;
        wr(OFS_DELAY_HIGH, hi);
        wr(OFS_DELAY_LOW, lo);
        fork disp.pulse_sync(); join_none
        repeat (8) @(negedge CORE_CLK);
        chk8({7'h00, DELAYING}, 8'h01, "delaying");
        wait_start();
        chkn(n + 8, 3 + ticks * 1357 / 10, 4, "delay");
    endtask
    task automatic test_regs();
        logic [7:0] a [7] = '{OFS_IRQ_EN2, OFS_DELAY_LOW, OFS_DELAY_HIGH, OFS_SUB_ONE_LOW,
            OFS_SUB_ONE_HIGH, OFS_SUB_TWO_LOW, OFS_SUB_TWO_HIGH};
        logic [7:0] d [7] = '{8'h9F, 8'hA5, 8'h5A, 8'h3C, 8'h3F, 8'hC3, 8'h2A};
        for (int i = 0; i < 7; i++)
            rd(a[i], REG_RESET);
        for (int i = 0; i < 7; i++)
            wr(a[i], d[i]);
        for (int i = 0; i < 7; i++)
            rd(a[i], d[i]);
        wr(8'hDF, 8'h77);
        rd(8'hDF, UNMAPPED_READ);
        {REG_ADDR, REG_WDATA, REG_WR} = {OFS_IRQ_EN2, 8'h81, 1'b1};
        @(negedge CORE_CLK) REG_WR = 1'b0;
        rd(OFS_IRQ_EN2, 8'h81);
        wr(OFS_SUB_ONE_LOW, 8'h00);
        wr(OFS_SUB_ONE_HIGH, 8'h00);
        wr(OFS_SUB_TWO_LOW, 8'h0C);
        wr(OFS_SUB_TWO_HIGH, 8'h00);
        $display("test_regs done");
    endtask
    task automatic test_events();
        for (int i = 0; i < 8; i++)
        begin
            wr(OFS_IRQ_EN2, (8'h01 << i) & IRQ_EN_MASK);
            EVENT_IN = 8'hFF;
            @(negedge CORE_CLK) chk8(EVENT_GATED, (8'h01 << i) & IRQ_EN_MASK, "gate");
        end
        $display("test_events done");
    endtask
    task automatic test_delays();
        run_delay(8'h00, 8'h05, 24);
        run_delay(8'h00, 8'h18, 24);
        run_delay(8'h00, 8'h19, 25);
        run_delay(8'h01, 8'h00, 256);
        $display("test_delays done");
    endtask
    task automatic test_restart();
        run_delay(8'h00, 8'h1E, 30);
        fork disp.pulse_sync(); join_none
        repeat (1357) @(negedge CORE_CLK);
        fork disp.pulse_sync(); join_none
        wait_start();
        chkn(n, 3 + 30 * 1357 / 10, 140, "restart");
        $display("test_restart done");
    endtask
    task automatic test_single();
        wait_strobe();
        chkn(n, 5000, 0, "no period strobe");
        disp.pulse_done();
        wait_strobe();
        chkn(n, 0, 1, "end strobe");
        chk8({7'h00, ph}, 8'h00, "end phase");
        $display("test_single done");
    endtask
    task automatic test_subsample();
        wr(OFS_SUB_ONE_LOW, 8'h0A);
        run_delay(8'h00, 8'h00, 24);
        for (int i = 0; i < 4; i++)
        begin
            wait_strobe();
            chkn(n, i[0] ? 1627 : (i ? 1356 : 1357), 4, "period");
            chk8({7'h00, ph}, {7'h00, i[0]}, "phase");
        end
        fork disp.pulse_sync(); join_none
        repeat (20) @(negedge CORE_CLK);
        chk8({7'h00, DELAYING}, 8'h01, "resync");
        MEAS_EN = 1'b0;
        @(negedge CORE_CLK) chk8({6'h00, DELAYING, INTEG_START}, 8'h00, "abort");
        $display("test_subsample done");
    endtask
    initial
    begin
        {RST, REG_WR, REG_RD, MEAS_EN} = 4'h8;
        {REG_ADDR, REG_WDATA, EVENT_IN} = 24'h000000;
        repeat (3) @(negedge CORE_CLK);
        RST = 1'b0;
        test_regs();
        test_events();
        test_delays();
        test_restart();
        test_single();
        test_subsample();
        wrap_up(0);
    end
endmodule
